// ===== hw/bfx_consts.vh
// Constants for the branch, bit and flag execution block
`ifndef BFX_CONSTS_VH
`define BFX_CONSTS_VH

// Status flag positions
`define BFX_FLAG_C 3'd0
`define BFX_FLAG_Z 3'd1
`define BFX_FLAG_N 3'd2
`define BFX_FLAG_V 3'd3
`define BFX_FLAG_S 3'd4
`define BFX_FLAG_H 3'd5
`define BFX_FLAG_T 3'd6
`define BFX_FLAG_I 3'd7

// Operation codes on i_op_code
`define BFX_OP_NOP 5'h00
`define BFX_OP_BR_FLAG_SET 5'h01
`define BFX_OP_BR_FLAG_CLR 5'h02
`define BFX_OP_BR_SIGNED_GE 5'h03
`define BFX_OP_BR_SIGNED_LT 5'h04
`define BFX_OP_IO_BIT_SET 5'h05
`define BFX_OP_IO_BIT_CLR 5'h06
`define BFX_OP_SHL 5'h07
`define BFX_OP_SHR 5'h08
`define BFX_OP_ROL 5'h09
`define BFX_OP_ROR 5'h0a
`define BFX_OP_ASR 5'h0b
`define BFX_OP_FLAG_SET 5'h0c
`define BFX_OP_FLAG_CLR 5'h0d
`define BFX_OP_BIT_TO_T 5'h0e
`define BFX_OP_T_TO_BIT 5'h0f
`define BFX_OP_IRQ_ON 5'h10
`define BFX_OP_IRQ_OFF 5'h11

// Highest bit-addressable I/O address
`define BFX_IO_BIT_MAX 6'h1f

// Register map (byte addresses)
`define BFX_REG_FLAGS 8'h00
`define BFX_REG_CTRL 8'h04
`define BFX_REG_COUNT 8'h08

// Reset values
`define BFX_FLAGS_RST 8'h00
`define BFX_CTRL_RST 1'b1

// Extra cycles beyond the first
`define BFX_STALL_BRANCH 1'b1
`define BFX_STALL_IO_BIT 1'b1

`endif

// ===== hw/bfx_exec.v
// Branch, bit, shift and flag instruction execution with AHB-Lite register access
`timescale 1ns/1ps
`include "bfx_consts.vh"

module bfx_exec #(
  parameter PCW = 12
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_srst,
  // Instruction issue
  input wire i_op_valid,
  input wire [4:0] i_op_code,
  input wire [2:0] i_op_bit,
  input wire [6:0] i_op_offset,
  input wire [5:0] i_op_ioaddr,
  input wire [7:0] i_op_rdata,
  input wire [PCW-1:0] i_pc,
  output wire o_op_ready,
  // Program counter load
  output reg o_pc_load,
  output reg [PCW-1:0] o_pc_target,
  // Working register write-back
  output reg o_rd_we,
  output reg [7:0] o_rd_wdata,
  // I/O bit write
  output reg o_io_we,
  output reg [5:0] o_io_addr,
  output reg [7:0] o_io_wmask,
  output reg [7:0] o_io_wdata,
  // Status flags to the core
  output wire [7:0] o_status_flags,
  // AHB-Lite slave
  input wire i_hsel,
  input wire [7:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire o_hreadyout,
  output wire o_hresp,
  output reg [31:0] o_hrdata
);

  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg ctrl_en_q;
  reg [15:0] count_q;
  reg busy_q;
  reg stall_d;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg cond;
  reg [8:0] sh;
  wire accept;
  wire ahb_go;
  wire [PCW-1:0] target;

  // One-hot mask for a bit number
  function [7:0] bit_mask;
    input [2:0] b;
    begin
      bit_mask = 8'h01 << b;
    end
  endfunction

  // Replaces one bit of a byte, others kept
  function [7:0] bit_put;
    input [7:0] v;
    input [2:0] b;
    input t;
    begin
      bit_put = (v & ~bit_mask(b)) | (t ? bit_mask(b) : 8'h00);
    end
  endfunction

  // Returns {carry, result}
  function [8:0] shift_op;
    input [4:0] code;
    input [7:0] v;
    input c;
    begin
      case (code)
        `BFX_OP_SHL: shift_op = {v[7], v[6:0], 1'b0};
        `BFX_OP_SHR: shift_op = {v[0], 1'b0, v[7:1]};
        `BFX_OP_ROL: shift_op = {v[7], v[6:0], c};
        `BFX_OP_ROR: shift_op = {v[0], c, v[7:1]};
        `BFX_OP_ASR: shift_op = {v[0], v[7], v[7:1]};
        default: shift_op = {c, v};
      endcase
    end
  endfunction

  assign o_status_flags = flags_q;
  assign o_op_ready = ctrl_en_q & ~busy_q;
  assign accept = i_op_valid & o_op_ready;
  // Sign-extended word displacement past the branch word
  assign target = i_pc + {{(PCW-7){i_op_offset[6]}}, i_op_offset} + {{(PCW-1){1'b0}}, 1'b1};

  always @*
  begin
    flags_d = flags_q;
    stall_d = 1'b0;
    cond = 1'b0;
    sh = shift_op(i_op_code, i_op_rdata, flags_q[`BFX_FLAG_C]);
    case (i_op_code)
      // One index covers C, Z, N, V, S, H, T and I variants
      `BFX_OP_BR_FLAG_SET: cond = flags_q[i_op_bit];
      `BFX_OP_BR_FLAG_CLR: cond = ~flags_q[i_op_bit];
      `BFX_OP_BR_SIGNED_GE: cond = ~(flags_q[`BFX_FLAG_N] ^ flags_q[`BFX_FLAG_V]);
      `BFX_OP_BR_SIGNED_LT: cond = flags_q[`BFX_FLAG_N] ^ flags_q[`BFX_FLAG_V];
      `BFX_OP_IO_BIT_SET, `BFX_OP_IO_BIT_CLR: stall_d = `BFX_STALL_IO_BIT;
      `BFX_OP_SHL, `BFX_OP_SHR, `BFX_OP_ROL, `BFX_OP_ROR, `BFX_OP_ASR:
      begin
        flags_d[`BFX_FLAG_C] = sh[8];
        flags_d[`BFX_FLAG_Z] = (sh[7:0] == 8'h00);
        flags_d[`BFX_FLAG_N] = sh[7];
        flags_d[`BFX_FLAG_V] = sh[7] ^ sh[8];
      end
      `BFX_OP_FLAG_SET: flags_d[i_op_bit] = 1'b1;
      `BFX_OP_FLAG_CLR: flags_d[i_op_bit] = 1'b0;
      `BFX_OP_BIT_TO_T: flags_d[`BFX_FLAG_T] = i_op_rdata[i_op_bit];
      `BFX_OP_IRQ_ON: flags_d[`BFX_FLAG_I] = 1'b1;
      `BFX_OP_IRQ_OFF: flags_d[`BFX_FLAG_I] = 1'b0;
      default: flags_d = flags_q;
    endcase
    // Taken branch costs one extra cycle, flags untouched
    if (cond)
    begin
      stall_d = `BFX_STALL_BRANCH;
    end
  end

  assign ahb_go = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Execution side
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      busy_q <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_target <= {PCW{1'b0}};
      o_rd_we <= 1'b0;
      o_rd_wdata <= 8'h00;
      o_io_we <= 1'b0;
      o_io_addr <= 6'h00;
      o_io_wmask <= 8'h00;
      o_io_wdata <= 8'h00;
      count_q <= 16'h0000;
    end
    else
    begin
      busy_q <= accept & stall_d;
      o_pc_load <= accept & cond;
      o_rd_we <= 1'b0;
      o_io_we <= 1'b0;
      if (accept)
      begin
        count_q <= count_q + 16'h0001;
        if (cond)
        begin
          o_pc_target <= target;
        end
        case (i_op_code)
          `BFX_OP_SHL, `BFX_OP_SHR, `BFX_OP_ROL, `BFX_OP_ROR, `BFX_OP_ASR:
          begin
            o_rd_we <= 1'b1;
            o_rd_wdata <= sh[7:0];
          end
          `BFX_OP_T_TO_BIT:
          begin
            o_rd_we <= 1'b1;
            o_rd_wdata <= bit_put(i_op_rdata, i_op_bit, flags_q[`BFX_FLAG_T]);
          end
          `BFX_OP_IO_BIT_SET, `BFX_OP_IO_BIT_CLR:
          begin
            // Mask keeps neighbouring write-one-to-clear flags safe
            o_io_we <= (i_op_ioaddr <= `BFX_IO_BIT_MAX);
            o_io_addr <= i_op_ioaddr;
            o_io_wmask <= bit_mask(i_op_bit);
            o_io_wdata <= (i_op_code == `BFX_OP_IO_BIT_SET) ? bit_mask(i_op_bit) : 8'h00;
          end
          default: o_rd_we <= 1'b0;
        endcase
      end
    end
  end

  // Flags and bus registers; an executing op wins over a bus write
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      flags_q <= `BFX_FLAGS_RST;
      ctrl_en_q <= `BFX_CTRL_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      o_hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= ahb_go & i_hwrite;
      if (ahb_go)
      begin
        wr_addr_q <= i_haddr;
      end
      if (ahb_go & ~i_hwrite)
      begin
        case (i_haddr)
          `BFX_REG_FLAGS: o_hrdata <= {24'h000000, flags_q};
          `BFX_REG_CTRL: o_hrdata <= {31'h00000000, ctrl_en_q};
          `BFX_REG_COUNT: o_hrdata <= {16'h0000, count_q};
          default: o_hrdata <= 32'h00000000;
        endcase
      end
      if (wr_pend_q && wr_addr_q == `BFX_REG_CTRL)
      begin
        ctrl_en_q <= i_hwdata[0];
      end
      if (accept)
      begin
        flags_q <= flags_d;
      end
      else if (wr_pend_q && wr_addr_q == `BFX_REG_FLAGS)
      begin
        flags_q <= i_hwdata[7:0];
      end
    end
  end

endmodule // bfx_exec

// ===== test/bfx_exec_properties.sv
// Concurrent checks on the execution block ports
`timescale 1ns/1ps
module bfx_chk (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_srst,
  // Instruction side
  input wire i_op_valid,
  input wire [4:0] i_op_code,
  input wire [2:0] i_op_bit,
  input wire [5:0] i_op_ioaddr,
  input wire [7:0] i_op_rdata,
  input wire o_op_ready,
  input wire o_pc_load,
  input wire o_rd_we,
  input wire [7:0] o_rd_wdata,
  input wire o_io_we,
  input wire [7:0] o_io_wmask,
  input wire [7:0] o_status_flags
);
  wire acc = i_op_valid & o_op_ready;
  wire [7:0] f = o_status_flags;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  AST_BR_TAKEN: assert property (acc && i_op_code == 5'h01 && f[i_op_bit] |=> o_pc_load ##1 !o_pc_load)
    else $error("taken branch pulse wrong");
  AST_BR_FAIL: assert property (acc && i_op_code == 5'h02 && f[i_op_bit] |=> !o_pc_load)
    else $error("failed branch loaded pc");
  AST_BR_GE: assert property (acc && i_op_code == 5'h03 && !(f[2] ^ f[3]) |=> o_pc_load)
    else $error("signed branch not taken");
  AST_BR_KEEP: assert property (acc && i_op_code inside {[1:4]} |=> $stable(f))
    else $error("branch changed flags");
  AST_IO_SET: assert property (acc && i_op_code == 5'h05 && i_op_ioaddr <= 6'h1f
    |=> o_io_we && o_io_wmask == (8'h01 << $past(i_op_bit)) && !o_op_ready)
    else $error("io bit write wrong");
  AST_IO_HIGH: assert property (acc && i_op_code inside {5, 6} && i_op_ioaddr > 6'h1f |=> !o_io_we)
    else $error("io write above range");
  AST_SHL: assert property (acc && i_op_code == 5'h07 |=> o_rd_we && o_rd_wdata == ($past(i_op_rdata) << 1))
    else $error("left shift result wrong");
  AST_SH_V: assert property (acc && i_op_code inside {[7:11]} |=> f[3] == (f[2] ^ f[0]))
    else $error("shift overflow wrong");
  AST_IRQ_ON: assert property (acc && i_op_code == 5'h10 |=> f[7])
    else $error("interrupt enable not set");
endmodule // bfx_chk
bind bfx_exec bfx_chk bfx_chk_i (.i_clk_sys, .i_srst, .i_op_valid, .i_op_code, .i_op_bit, .i_op_ioaddr,
  .i_op_rdata, .o_op_ready, .o_pc_load, .o_rd_we, .o_rd_wdata, .o_io_we, .o_io_wmask, .o_status_flags);

// ===== test/tb_top.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  reg clk = 0, rst = 1, vld = 0, hsel = 0, hwr = 0;
  reg [4:0] code = 0;
  reg [2:0] bt = 0;
  reg [6:0] off = 0;
  reg [5:0] ioa = 0;
  reg [7:0] rd = 0, ha = 0, fl;
  reg [1:0] htr = 0;
  reg [31:0] hwd = 0, q;
  reg [8:0] e;
  integer miscompares = 0, check_count = 0, i, k;
  wire rdy, pcl, rwe, iwe, hr, hrsp;
  wire [11:0] tgt;
  wire [5:0] iad;
  wire [7:0] rwd, msk, iwd, sf;
  wire [31:0] hrd;
  bfx_exec bfx_exec_i (.i_clk_sys(clk), .i_srst(rst), .i_op_valid(vld), .i_op_code(code), .i_op_bit(bt),
    .i_op_offset(off), .i_op_ioaddr(ioa), .i_op_rdata(rd), .i_pc(12'h100), .o_op_ready(rdy), .o_pc_load(pcl),
    .o_pc_target(tgt), .o_rd_we(rwe), .o_rd_wdata(rwd), .o_io_we(iwe), .o_io_addr(iad), .o_io_wmask(msk),
    .o_io_wdata(iwd), .o_status_flags(sf), .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr), .i_hwrite(hwr),
    .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hr), .o_hreadyout(hr), .o_hresp(hrsp), .o_hrdata(hrd));
  initial forever #2.5 clk = ~clk;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Bounded wait for hready (b=1) or op ready (b=0) sampled at an edge
  task wt(input b);
    begin
      k = 0;
      do begin @(posedge clk); k++; end while ((b ? hr : rdy) !== 1'b1 && k < 20);
      if ((b ? hr : rdy) !== 1'b1)
      begin
        miscompares++;
        conclude;
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1; htr <= 2'h2; ha <= a; hwr <= w;
      wt(1);
      hsel <= 0; htr <= 0; hwd <= d;
      wt(1);
      q = hrd;
    end
  endtask
  task op(input [4:0] c, input [2:0] b, input [7:0] r, input [6:0] o, input [5:0] a);
    begin
      @(posedge clk);
      vld <= 1; code <= c; bt <= b; rd <= r; off <= o; ioa <= a;
      wt(0);
      vld <= 0;
      #1;
    end
  endtask
  // Returns {carry out, result}
  function [8:0] sh(input [4:0] c, input [7:0] v, input ci);
    case (c)
      5'h07: sh = {v, 1'b0};
      5'h08: sh = {v[0], 1'b0, v[7:1]};
      5'h09: sh = {v, ci};
      5'h0a: sh = {v[0], ci, v[7:1]};
      default: sh = {v[0], v[7], v[7:1]};
    endcase
  endfunction
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 0;
    ahb(0, 8'h00, 0); `CHK(q, 32'h0)
    ahb(0, 8'h04, 0); `CHK(q, 32'h1)
    ahb(0, 8'h0c, 0); `CHK(q, 32'h0)
    $display("test reset done");
    fl = 0;
    for (i = 0; i < 16; i++)
    begin
      op(i < 8 ? 5'h0c : 5'h0d, i[2:0], 0, 0, 0);
      fl[i % 8] = i < 8;
      `CHK(sf, fl)
    end
    op(5'h10, 0, 0, 0, 0); `CHK(sf, 8'h80)
    op(5'h11, 0, 0, 0, 0); `CHK(sf, 8'h00)
    $display("test flags done");
    for (i = 0; i < 10; i++)
    begin
      e = sh(5'(7 + i % 5), i < 5 ? 8'h81 : 8'h01, fl[0]);
      op(5'(7 + i % 5), 0, i < 5 ? 8'h81 : 8'h01, 0, 0);
      fl[3:0] = {e[7] ^ e[8], e[7], e[7:0] == 0, e[8]};
      `CHK({rwe, rwd, sf}, {1'b1, e[7:0], fl})
    end
    $display("test shifts done");
    ahb(1, 8'h00, 32'h55);
    fl = 8'h55;
    for (i = 0; i < 16; i++)
    begin
      op(i < 8 ? 5'h01 : 5'h02, i[2:0], 0, 7'h40, 0);
      `CHK({pcl, sf}, {fl[i % 8] ^ (i > 7), fl})
      if (fl[i % 8] ^ (i > 7))
        `CHK({rdy, tgt}, {1'b0, 12'h0c1})
    end
    // N set, V clear: less-than holds
    op(5'h03, 0, 0, 7'h40, 0); `CHK(pcl, 1'b0)
    op(5'h04, 0, 0, 7'h01, 0); `CHK({pcl, tgt}, {1'b1, 12'h102})
    $display("test branches done");
    op(5'h05, 3, 0, 0, 6'h1f); `CHK({iwe, rdy, iad, msk, iwd}, {2'b10, 6'h1f, 16'h0808})
    op(5'h06, 7, 0, 0, 6'h00); `CHK({iwe, rdy, iad, msk, iwd}, {2'b10, 6'h00, 16'h8000})
    op(5'h05, 0, 0, 0, 6'h20); `CHK({iwe, sf}, {1'b0, fl})
    $display("test io done");
    op(5'h0e, 7, 8'h7f, 0, 0); fl[6] = 0; `CHK(sf, fl)
    op(5'h0f, 1, 8'hff, 0, 0); `CHK({rwe, rwd, sf}, {1'b1, 8'hfd, fl})
    // Accepted ops so far: 16 + 2 + 10 + 16 + 2 + 3 + 2
    ahb(0, 8'h08, 0); `CHK(q, 32'h33)
    `CHK(hrsp, 1'b0)
    ahb(1, 8'h04, 0); #1; `CHK(rdy, 1'b0)
    ahb(1, 8'h04, 1); #1; `CHK(rdy, 1'b1)
    $display("test bit transfer and control done");
    conclude;
  end
endmodule // tb_top
